/* hw/vchl_pkg.sv */
// package for the channel capability and header log register group
// assumes a plain register port with byte addresses and 32-bit data
package vchl_pkg;

    // register byte offsets
    localparam logic [11:0] VCHL_OFS_HDR0 = 12'h11c;
    localparam logic [11:0] VCHL_OFS_HDR1 = 12'h120;
    localparam logic [11:0] VCHL_OFS_HDR2 = 12'h124;
    localparam logic [11:0] VCHL_OFS_HDR3 = 12'h128;
    localparam logic [11:0] VCHL_OFS_CAP_HDR = 12'h140;
    localparam logic [11:0] VCHL_OFS_CAP_ONE = 12'h144;
    localparam logic [11:0] VCHL_OFS_CAP_TWO = 12'h148;
    localparam logic [11:0] VCHL_OFS_CTL_STS = 12'h14c;
    // table window and load timing, chosen locally
    localparam logic [11:0] VCHL_OFS_TABLE = 12'h170;
    localparam int VCHL_TABLE_WORDS = 4;
    localparam int VCHL_LOAD_NS = 100;
    localparam int VCHL_CLK_NS = 25;
    localparam logic [3:0] VCHL_LOAD_CYCLES = 4'((VCHL_LOAD_NS + VCHL_CLK_NS - 1) / VCHL_CLK_NS);

    // capability header fields
    localparam logic [15:0] VCHL_CAP_ID = 16'h0002;
    localparam logic [3:0] VCHL_CAP_VER = 4'h1;
    localparam logic [11:0] VCHL_NEXT_PTR = 12'h20c;
    // capability one fields
    localparam logic [1:0] VCHL_REF_CLK_100NS = 2'h0;
    localparam logic [1:0] VCHL_ENTRY_SIZE_4B = 2'h2;
    // capability two fields
    localparam logic [7:0] VCHL_ARB_CAP_ON = 8'h03;
    localparam logic [7:0] VCHL_TBL_OFS_ON = 8'h03;
    // control field positions
    localparam int VCHL_CTL_LOAD_BIT = 0;
    localparam int VCHL_CTL_SEL_LO = 1;
    localparam int VCHL_STS_TBL_BIT = 16;
    localparam logic [2:0] VCHL_SEL_MAX = 3'h1;

    // error event delivered to the header log
    typedef struct packed {
        logic valid;
        logic masked;
        logic [127:0] header;
    } vchl_err_s;

    // eeprom auto-load of the count fields
    typedef struct packed {
        logic valid;
        logic [2:0] ext_count;
        logic [2:0] lp_count;
    } vchl_eep_s;

endpackage : vchl_pkg

/* hw/vchl_regs.sv */
// this file holds the whole register group
// assumes a single core clock; strap and eeprom inputs come from outside
// assumes the register port never stalls: read data always follow one cycle later
// assumes the error source already decoded the mask bit into i_err.masked
`timescale 1ns/1ps
`timescale 1ns/1ps
`default_nettype none
module vchl_regs
    import vchl_pkg::*;
#(
    parameter int TABLE_WORDS = VCHL_TABLE_WORDS
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_por_n,
    input wire logic i_clk_en,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_second_channel_strap,
    input wire vchl_eep_s i_eep,
    input wire vchl_err_s i_err,
    output logic o_err_msg,
    output logic [2:0] o_arb_scheme,
    output logic o_table_apply,
    output logic [32*TABLE_WORDS-1:0] o_arb_table
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // swap bytes so the first wire byte sits in the top lane
    // used four times on the capture path, once per logged dword
    // the header arrives with its first byte in the low lane of each dword
    function automatic logic [31:0] vchl_swap(input logic [31:0] d);
        vchl_swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction : vchl_swap

    // ------------------------------------------------------------
    // strap synchroniser
    // ------------------------------------------------------------
    logic strap_meta;
    logic strap_sync;
    logic strap_taken;
    logic [1:0] strap_age;
    logic [2:0] ext_count;
    logic [2:0] lp_count;

    // the pin is asynchronous; only strap_sync is looked at
    // both flops reset low, so the settled level is only known two
    // enabled edges after release; the capture below waits for that
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
        end
        else if (i_clk_en)
        begin
            strap_meta <= i_second_channel_strap;
            strap_sync <= strap_meta;
        end
    end

    // ------------------------------------------------------------
    // count fields
    // ------------------------------------------------------------
    // strap caught once the synchroniser has settled, eeprom can override later
    // reading the sync flop any earlier would catch its reset value, not the pin
    // an eeprom load before the capture wins and blocks the strap for good
    // limitation: the upper count bits only ever change through eeprom
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            strap_taken <= 1'b0;
            strap_age <= 2'h0;
            ext_count <= 3'h0;
            lp_count <= 3'h0;
        end
        else if (i_clk_en)
        begin
            // age saturates at two: the sync flop then holds the real pin level
            if (strap_age != 2'h2)
                strap_age <= strap_age + 2'h1;
            if (i_eep.valid)
            begin
                ext_count <= i_eep.ext_count;
                lp_count <= i_eep.lp_count;
                strap_taken <= 1'b1;
            end
            else if (!strap_taken && (strap_age == 2'h2))
            begin
                ext_count <= {2'h0, strap_sync};
                strap_taken <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // header log
    // ------------------------------------------------------------
    logic [127:0] hdr_log;
    logic hdr_full;
    wire log_take = i_err.valid && !i_err.masked && !hdr_full;

    // sticky: only power-on reset clears it, so a warm reset keeps the log
    // first-error semantics: once full, later events are dropped until power-on
    // a masked event neither fills the log nor locks it
    // trade-off: no way to rearm the log from software, by intent
    always_ff @(posedge i_core_clk or negedge i_por_n)
    begin
        if (!i_por_n)
        begin
            hdr_log <= 128'h0;
            hdr_full <= 1'b0;
        end
        else if (i_clk_en && log_take)
        begin
            hdr_log <= {vchl_swap(i_err.header[127:96]), vchl_swap(i_err.header[95:64]),
                vchl_swap(i_err.header[63:32]), vchl_swap(i_err.header[31:0])};
            hdr_full <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // control and status share one word: low half control, bit 16 status
    // table window is word aligned; unaligned or out-of-range hits decode as none
    // hazard: the table index uses two address bits, sized for four words
    wire hit_ctl = i_addr == VCHL_OFS_CTL_STS;
    wire [11:0] tbl_rel = i_addr - VCHL_OFS_TABLE;
    wire hit_tbl = (i_addr >= VCHL_OFS_TABLE) && (tbl_rel[11:2] < 10'(TABLE_WORDS))
        && (i_addr[1:0] == 2'h0);
    wire wr_ctl = i_wr && hit_ctl;
    wire wr_tbl = i_wr && hit_tbl;
    wire load_req = wr_ctl && i_wdata[VCHL_CTL_LOAD_BIT];
    wire [2:0] sel_in = i_wdata[VCHL_CTL_SEL_LO +: 3];
    // anything above the supported codes falls back to the default scheme
    wire [2:0] sel_fix = (sel_in <= VCHL_SEL_MAX) ? sel_in : 3'h0;

    // ------------------------------------------------------------
    // control, table and load sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VCHL_IDLE = 2'b01,
        VCHL_LOAD = 2'b10
    } vchl_state_e;

    vchl_state_e state;
    vchl_state_e next_state;
    logic [3:0] load_cnt;
    logic [2:0] arb_sel;
    logic tbl_status;
    logic [31:0] tbl_mem [TABLE_WORDS];
    logic [32*TABLE_WORDS-1:0] active_tbl;
    logic apply_pulse;
    wire load_done = (state == VCHL_LOAD) && (load_cnt == 4'h1);

    // next state of the load sequencer
    // a load request during a running load is ignored, the walk is not restarted
    // the walk length is a fixed count; the arbiter sees the table only at the end
    always_comb
    begin
        next_state = state;
        unique case (state)
            VCHL_IDLE: if (load_req) next_state = VCHL_LOAD;
            VCHL_LOAD: if (load_done) next_state = VCHL_IDLE;
            default: next_state = VCHL_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= VCHL_IDLE;
            load_cnt <= 4'h0;
        end
        else if (i_clk_en)
        begin
            state <= next_state;
            load_cnt <= (state == VCHL_IDLE) ? VCHL_LOAD_CYCLES : load_cnt - 4'h1;
        end
    end

    // load counter is primed while idle and counts down during the walk
    // scheme select; only valid codes are stored
    // storing the folded code keeps read-back and arbiter in agreement
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            arb_sel <= 3'h0;
        else if (i_clk_en && wr_ctl)
            arb_sel <= sel_fix;
    end

    // table entries written by software
    // no reset: contents only matter once software has written and loaded them
    // writes in the finishing cycle of a load land here but reach the arbiter next load
    always_ff @(posedge i_core_clk)
    begin
        if (i_clk_en && wr_tbl)
            tbl_mem[tbl_rel[3:2]] <= i_wdata;
    end

    // status: a table write in the finishing cycle wins over the clear
    // so software never loses the hint that the copy in use is stale
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            tbl_status <= 1'b0;
        else if (i_clk_en)
        begin
            if (wr_tbl)
                tbl_status <= 1'b1;
            else if (load_done)
                tbl_status <= 1'b0;
        end
    end

    // active table copied into the arbiter when the load finishes
    // the apply pulse is registered on the same edge as the copy, so both
    // change together for the arbiter when it reacts to the pulse
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            active_tbl <= '0;
            apply_pulse <= 1'b0;
        end
        else if (i_clk_en)
        begin
            apply_pulse <= load_done;
            if (load_done)
                for (int k = 0; k < TABLE_WORDS; k++)
                    active_tbl[32*k +: 32] <= tbl_mem[k];
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [31:0] rd_cap_hdr = {VCHL_NEXT_PTR, VCHL_CAP_VER, VCHL_CAP_ID};
    wire [31:0] rd_cap_one = {20'h0, VCHL_ENTRY_SIZE_4B, VCHL_REF_CLK_100NS, 1'b0, lp_count,
        1'b0, ext_count};
    wire [7:0] cap_two_arb = ext_count[0] ? VCHL_ARB_CAP_ON : 8'h00;
    wire [7:0] cap_two_ofs = ext_count[0] ? VCHL_TBL_OFS_ON : 8'h00;
    wire [31:0] rd_cap_two = {cap_two_ofs, 16'h0, cap_two_arb};
    // load bit always reads zero
    wire [31:0] rd_ctl = {15'h0, tbl_status, 12'h0, arb_sel, 1'b0};
    wire [31:0] rd_tbl = hit_tbl ? tbl_mem[tbl_rel[3:2]] : 32'h0;
    // unmapped addresses read zero
    // reserved bits are tied low in every word above, writes never reach them
    // the mux is a priority chain; addresses are exclusive so order is free
    wire [31:0] rd_mux =
        (i_addr == VCHL_OFS_HDR0) ? hdr_log[31:0] :
        (i_addr == VCHL_OFS_HDR1) ? hdr_log[63:32] :
        (i_addr == VCHL_OFS_HDR2) ? hdr_log[95:64] :
        (i_addr == VCHL_OFS_HDR3) ? hdr_log[127:96] :
        (i_addr == VCHL_OFS_CAP_HDR) ? rd_cap_hdr :
        (i_addr == VCHL_OFS_CAP_ONE) ? rd_cap_one :
        (i_addr == VCHL_OFS_CAP_TWO) ? rd_cap_two :
        hit_ctl ? rd_ctl : rd_tbl;

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // read data stand one cycle and return to zero, so a stale word never lingers
    // the error message pulse is not tied to the log: every unmasked event signals
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= 32'h0;
            o_err_msg <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_rdata <= i_rd ? rd_mux : 32'h0;
            o_err_msg <= i_err.valid && !i_err.masked;
        end
    end

    // these three are plain flops, renamed onto the ports
    assign o_arb_scheme = arb_sel;
    assign o_table_apply = apply_pulse;
    assign o_arb_table = active_tbl;

endmodule : vchl_regs
`default_nettype wire

/* verif/vchl_regs_monitor.sv */
// checker on the ports of the register group
// assumes one core clock and the plain register port strobes
`timescale 1ns/1ps
`default_nettype none
module vchl_regs_mon
    import vchl_pkg::*;
#(
    parameter int TABLE_WORDS = VCHL_TABLE_WORDS
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_por_n,
    input wire logic i_clk_en,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_second_channel_strap,
    input wire vchl_eep_s i_eep,
    input wire vchl_err_s i_err,
    input wire logic o_err_msg,
    input wire logic [2:0] o_arb_scheme,
    input wire logic o_table_apply,
    input wire logic [32*TABLE_WORDS-1:0] o_arb_table
);
    // ----
    // port relations
    // ----
    // decode once; a strobe only counts when the clock enable lets it in
    wire rd_en = i_clk_en & i_rd;
    wire ctl_wr = i_clk_en & i_wr & (i_addr == VCHL_OFS_CTL_STS);
    wire [2:0] sel_exp = (i_wdata[3:1] > VCHL_SEL_MAX) ? 3'h0 : i_wdata[3:1];
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n || !i_por_n);
    property p_cap_hdr;
        rd_en & (i_addr == VCHL_OFS_CAP_HDR) |=> o_rdata == 32'h20c1_0002;
    endproperty
    a_cap_hdr: assert property (p_cap_hdr) else $error("cap header");
    property p_cap_one;
        rd_en & (i_addr == VCHL_OFS_CAP_ONE) |=> o_rdata[31:7] == 25'h10 && !o_rdata[3];
    endproperty
    a_cap_one: assert property (p_cap_one) else $error("cap one");
    property p_cap_two;
        rd_en & (i_addr == VCHL_OFS_CAP_TWO) |=> o_rdata[23:8] == 16'h0
            && o_rdata[7:0] == o_rdata[31:24] && o_rdata[7:0] inside {8'h0, 8'h03};
    endproperty
    a_cap_two: assert property (p_cap_two) else $error("cap two");
    property p_ctl_rd;
        rd_en & (i_addr == VCHL_OFS_CTL_STS) |=> !o_rdata[0] && o_rdata[15:4] == 12'h0;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("load bit read");
    property p_sel;
        ctl_wr |=> o_arb_scheme == $past(sel_exp);
    endproperty
    a_sel: assert property (p_sel) else $error("scheme select");
    // the load walk is a few cycles, so eight is a loose but finite bound
    property p_apply;
        ctl_wr & i_wdata[0] |-> ##[1:8] o_table_apply;
    endproperty
    a_apply: assert property (p_apply) else $error("table not applied");
    property p_mask;
        i_clk_en & i_err.valid & i_err.masked |=> !o_err_msg;
    endproperty
    a_mask: assert property (p_mask) else $error("masked event signalled");
    property p_rd_idle;
        i_clk_en & !i_rd |=> o_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule : vchl_regs_mon
bind vchl_regs vchl_regs_mon #(.TABLE_WORDS(TABLE_WORDS)) vchl_regs_mon_inst (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n), .i_clk_en(i_clk_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_second_channel_strap(i_second_channel_strap), .i_eep(i_eep), .i_err(i_err),
    .o_err_msg(o_err_msg), .o_arb_scheme(o_arb_scheme), .o_table_apply(o_table_apply),
    .o_arb_table(o_arb_table));
`default_nettype wire

/* verif/vchl_regs_tb.sv */
// bench for the register group: caps, strap, eeprom, control, table, log
// assumes four table words and the load timing of the package
`timescale 1ns/1ps
`default_nettype none
module vchl_regs_tb
    import vchl_pkg::*;
;
    // ----
    // stimulus and checking
    // ----
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic por_n = 1'b0;
    logic en = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic strap = 1'b0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    vchl_eep_s eep = '0;
    vchl_err_s err = '0;
    logic err_msg;
    logic apply;
    logic [2:0] scheme;
    logic [127:0] tbl;
    int mismatches = 0;
    int num_checks = 0;
    localparam logic [127:0] H1 = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;

    // 40 MHz core clock
    always #12.5 clk = ~clk;

    vchl_regs vchl_regs_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n),
        .i_clk_en(en), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_second_channel_strap(strap), .i_eep(eep), .i_err(err), .o_err_msg(err_msg),
        .o_arb_scheme(scheme), .o_table_apply(apply), .o_arb_table(tbl));

    // counts prints and ends the run; also the exit for a hung wait
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // bus cycles: strobes are one cycle, data sampled mid-cycle after the read
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask : rd_chk

    // four edges after release leave room for the strap synchroniser
    task automatic do_reset(input logic por, input logic s);
        strap <= s;
        rst_n <= 1'b0;
        if (por)
            por_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : do_reset

    task automatic inject(input logic m, input logic [127:0] h);
        @(posedge clk);
        err <= '{valid: 1'b1, masked: m, header: h};
        @(posedge clk);
        err.valid <= 1'b0;
        @(negedge clk);
        chk({31'h0, err_msg}, {31'h0, ~m});
    endtask : inject

    // each logged dword reads back with its bytes reversed
    task automatic log_chk(input logic [127:0] h);
        logic [31:0] w;
        for (int n = 0; n < 4; n++)
        begin
            w = h[32*n +: 32];
            rd_chk(VCHL_OFS_HDR0 + 12'(4 * n), {w[7:0], w[15:8], w[23:16], w[31:24]});
        end
    endtask : log_chk

    task automatic t_caps(input logic s);
        do_reset(1'b1, s);
        wr_reg(VCHL_OFS_CAP_HDR, 32'hffff_ffff);
        rd_chk(VCHL_OFS_CAP_HDR, 32'h20c1_0002);
        rd_chk(VCHL_OFS_CAP_ONE, {31'h400, s});
        rd_chk(VCHL_OFS_CAP_TWO, s ? 32'h0300_0003 : 32'h0);
        rd_chk(VCHL_OFS_CTL_STS, 32'h0);
    endtask : t_caps

    task automatic t_eep();
        @(posedge clk);
        eep <= '{valid: 1'b1, ext_count: 3'h5, lp_count: 3'h6};
        @(posedge clk);
        eep.valid <= 1'b0;
        rd_chk(VCHL_OFS_CAP_ONE, 32'h0000_0865);
    endtask : t_eep

    // every select code, then a write held off by the clock enable
    task automatic t_sel();
        logic [31:0] e;
        for (int c = 0; c < 8; c++)
        begin
            wr_reg(VCHL_OFS_CTL_STS, 32'(c) << 1);
            e = (c > 1) ? 32'h0 : 32'(c);
            rd_chk(VCHL_OFS_CTL_STS, e << 1);
            chk({29'h0, scheme}, e);
        end
        en <= 1'b0;
        wr_reg(VCHL_OFS_CTL_STS, 32'h2);
        en <= 1'b1;
        chk({29'h0, scheme}, 32'h0);
    endtask : t_sel

    task automatic t_table();
        int k;
        wr_reg(VCHL_OFS_TABLE, 32'hcafe_0123);
        rd_chk(VCHL_OFS_CTL_STS, 32'h0001_0000);
        wr_reg(VCHL_OFS_CTL_STS, 32'h3);
        for (k = 0; k < 20 && apply !== 1'b1; k++)
            @(negedge clk);
        if (k == 20)
        begin
            mismatches++;
            finish_test();
        end
        repeat (4) @(posedge clk);
        rd_chk(VCHL_OFS_CTL_STS, 32'h2);
        chk(tbl[31:0], 32'hcafe_0123);
    endtask : t_table

    // masked event, first capture, a later one ignored, warm reset kept
    task automatic t_err();
        do_reset(1'b1, 1'b0);
        inject(1'b1, H1);
        log_chk(128'h0);
        inject(1'b0, H1);
        log_chk(H1);
        inject(1'b0, ~H1);
        log_chk(H1);
        do_reset(1'b0, 1'b0);
        log_chk(H1);
        wr_reg(12'h100, 32'hffff_ffff);
        rd_chk(12'h100, 32'h0);
    endtask : t_err

    initial
    begin
        t_caps(1'b0);
        t_caps(1'b1);
        t_eep();
        t_sel();
        t_table();
        t_err();
        finish_test();
    end
endmodule : vchl_regs_tb
`default_nettype wire
